/* design/csr_core_regs.v */
// core special registers: data pointer, stack pointer, status word, power and configuration
`include "csr_core_defs.vh"

// Notes on behaviour
// - pointer is page, high, low bytes
// - pointer increment carries into page byte
// - push increments pointer before writing
// - stack pointer resets to 07h
// - three upper bits extend stack pointer
// - upper bits hidden while extension off
// - extended stack carries 00ff to 0100
// - plain stack wraps ff to 00
// - status bits 4,3 pick register bank
// - status word at d0h, resets 00h
// - power bit 7 doubles uart baud
// - power bit 6 enables serial wake
// - power bit 5 enables irq0 wake
// - power bit 4 disables latch strobe
// - writing power bit 1 enters power-down
// - bits 3,2 spare, bit 0 unimplemented
// - config bit 0 maps on-chip ram
// - map off lets accesses go external
// - config at afh resets 00h
// - pointer above 0007ffh always external
module csr_core_regs #(
    parameter ADDR_W = 8,
    parameter DATA_W = 8
) (
    input  wire              clk_sys,
    input  wire              rst_n,
    input  wire [ADDR_W-1:0] sfrAddr,
    input  wire              sfrWrite,
    input  wire              sfrRead,
    input  wire [DATA_W-1:0] sfrWriteData,
    input  wire              bitWrite,
    input  wire [2:0]        bitIndex,
    input  wire              bitValue,
    input  wire              pointerInc,
    input  wire              stackPush,
    input  wire              stackPop,
    input  wire              flagsUpdate,
    input  wire [3:0]        flagsIn,
    input  wire              serialIrq,
    input  wire              extIrq0PinN,
    input  wire              extIrq0EdgeSelect,
    output reg  [DATA_W-1:0] sfrReadData,
    output reg               sfrReadValid,
    output reg  [23:0]       memoryAddressPointer,
    output reg  [10:0]       stackAddress,
    output reg               stackWriteStrobe,
    output reg  [1:0]        activeBank,
    output reg               uartBaudDoubler,
    output reg               latchStrobeDisable,
    output reg               powerDown,
    output reg               onchipRamSelect,
    output reg               onchipRamMapEnable
);
    reg  [7:0]  powerControl_reg;
    reg  [7:0]  coreConfig_reg;
    reg  [7:0]  statusWord_reg;
    reg  [7:0]  stackTop_reg;
    reg  [7:0]  stackUpper_reg;
    reg  [7:0]  ptrLow_reg;
    reg  [7:0]  ptrHigh_reg;
    reg  [7:0]  ptrPage_reg;
    reg  [7:0]  readMux;
    reg  [10:0] stackNext;
    reg  [23:0] pointerNext;
    wire [10:0] stackCurrent;
    wire [23:0] pointerCurrent;
    wire        stackExtEnable;
    wire        powerDownState;
    wire        wakeEvent;
    wire        enterDown;
    wire        wrPower;
    wire        wrStatusBit;

    // register write strobe for one address
    function hit;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // eleven-bit stack address from its two bytes
    function [10:0] stackJoin;
        input [2:0] upper;
        input [7:0] top;
        begin
            stackJoin = {upper, top};
        end
    endfunction

    // 24-bit data pointer from its three bytes
    function [23:0] pointerJoin;
        input [7:0] page;
        input [7:0] high;
        input [7:0] low;
        begin
            pointerJoin = {page, high, low};
        end
    endfunction

    // on-chip ram only up to the limit; larger pointers always leave the chip
    function onchipHit;
        input        mapOn;
        input [23:0] ptr;
        begin
            onchipHit = mapOn && (ptr <= `CSR_RAM_LIMIT);
        end
    endfunction

    // upper three bits sit above the top byte
    assign stackCurrent   = stackJoin(stackUpper_reg[2:0], stackTop_reg);
    assign pointerCurrent = pointerJoin(ptrPage_reg, ptrHigh_reg, ptrLow_reg);
    // decoded write strobes and mode bits
    assign stackExtEnable = coreConfig_reg[`CSR_CFG_STKEXT];
    assign wrPower        = sfrWrite & hit(sfrAddr, `CSR_ADDR_PWR);
    assign wrStatusBit    = bitWrite & hit(sfrAddr, `CSR_ADDR_STATUS);
    // writing one to the down bit enters power-down
    assign enterDown      = wrPower & sfrWriteData[`CSR_PWR_DOWN];

    csr_power_wake u_wake (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .enterDown         (enterDown),
        .serialWakeEnable  (powerControl_reg[`CSR_PWR_SERWAKE]),
        .extIrq0WakeEnable (powerControl_reg[`CSR_PWR_IRQWAKE]),
        .extIrq0EdgeSelect (extIrq0EdgeSelect),
        .serialIrq         (serialIrq),
        .extIrq0PinN       (extIrq0PinN),
        .powerDown_reg     (powerDownState),
        .wakeEvent         (wakeEvent)
    );

    // next stack pointer for push/pop, width depends on extension
    always @* begin
        stackNext = stackCurrent;
        if (stackPush) begin
            // carry into upper bits when extended
            if (stackExtEnable)
                stackNext = stackCurrent + 11'h001;
            else
                stackNext = stackJoin(stackUpper_reg[2:0], stackTop_reg + 8'h01);
        end else if (stackPop) begin
            if (stackExtEnable)
                stackNext = stackCurrent - 11'h001;
            else
                stackNext = stackJoin(stackUpper_reg[2:0], stackTop_reg - 8'h01);
        end
    end

    // 24-bit increment, low/high overflow reaches page
    always @* begin
        pointerNext = pointerCurrent + 24'h000001;
    end

    // power control and configuration registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            powerControl_reg <= `CSR_RST_PWR;
            coreConfig_reg   <= `CSR_RST_CFG;
        end else begin
            // bit 0 masked off, spare bits writable
            if (wrPower)
                powerControl_reg <= (sfrWriteData & `CSR_PWR_WMASK) & 8'hfd;
            // only bits 7 and 0 exist
            if (sfrWrite && hit(sfrAddr, `CSR_ADDR_CFG))
                coreConfig_reg <= sfrWriteData & `CSR_CFG_WMASK;
        end
    end

    // status word: byte writes, bit writes, core flag updates
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            statusWord_reg <= `CSR_RST_STATUS;
        end else if (sfrWrite && hit(sfrAddr, `CSR_ADDR_STATUS)) begin
            statusWord_reg <= sfrWriteData;
        end else if (wrStatusBit) begin
            statusWord_reg[bitIndex] <= bitValue;
        end else if (flagsUpdate) begin
            statusWord_reg[`CSR_STS_CARRY]  <= flagsIn[3];
            statusWord_reg[`CSR_STS_AUX]    <= flagsIn[2];
            statusWord_reg[`CSR_STS_RANGE]  <= flagsIn[1];
            statusWord_reg[`CSR_STS_PARITY] <= flagsIn[0];
        end
    end

    // stack pointer bytes; push/pop beat software writes
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // stack starts at 07h, first push lands at 08h
            stackTop_reg   <= `CSR_RST_STACK;
            stackUpper_reg <= `CSR_RST_STKUP;
        end else if (stackPush || stackPop) begin
            stackTop_reg   <= stackNext[7:0];
            stackUpper_reg <= {5'h00, stackNext[10:8]};
        end else if (sfrWrite) begin
            if (hit(sfrAddr, `CSR_ADDR_STACK))
                stackTop_reg <= sfrWriteData;
            // upper bits ignore writes while disabled
            if (hit(sfrAddr, `CSR_ADDR_STKUP) && stackExtEnable)
                stackUpper_reg <= sfrWriteData & `CSR_STKUP_WMASK;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ptrLow_reg  <= `CSR_RST_PTR;
            ptrHigh_reg <= `CSR_RST_PTR;
            ptrPage_reg <= `CSR_RST_PTR;
        end else if (pointerInc) begin
            ptrLow_reg  <= pointerNext[7:0];
            ptrHigh_reg <= pointerNext[15:8];
            ptrPage_reg <= pointerNext[23:16];
        end else if (sfrWrite) begin
            if (hit(sfrAddr, `CSR_ADDR_PTRLOW))
                ptrLow_reg <= sfrWriteData;
            if (hit(sfrAddr, `CSR_ADDR_PTRHIGH))
                ptrHigh_reg <= sfrWriteData;
            if (hit(sfrAddr, `CSR_ADDR_PTRPAGE))
                ptrPage_reg <= sfrWriteData;
        end
    end

    // read multiplexer, unmapped addresses return zero
    always @* begin
        case (sfrAddr)
            `CSR_ADDR_PWR:     readMux = powerControl_reg;
            `CSR_ADDR_CFG:     readMux = coreConfig_reg;
            `CSR_ADDR_STATUS:  readMux = statusWord_reg;
            `CSR_ADDR_STACK:   readMux = stackTop_reg;
            `CSR_ADDR_STKUP:   readMux = stackExtEnable ? stackUpper_reg : 8'h00;
            `CSR_ADDR_PTRLOW:  readMux = ptrLow_reg;
            `CSR_ADDR_PTRHIGH: readMux = ptrHigh_reg;
            `CSR_ADDR_PTRPAGE: readMux = ptrPage_reg;
            default:           readMux = 8'h00;
        endcase
    end

    // read-back outputs, data is the state before the request edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sfrReadData  <= 8'h00;
            sfrReadValid <= 1'b0;
        end else begin
            // masked bits read as zero via stored masks
            sfrReadData  <= readMux;
            sfrReadValid <= sfrRead;
        end
    end

    // stack address and store strobe towards the internal ram
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stackAddress     <= {3'h0, `CSR_RST_STACK};
            stackWriteStrobe <= 1'b0;
        end else begin
            // write strobe follows the incremented address
            stackAddress     <= stackPush ? stackNext : stackCurrent;
            stackWriteStrobe <= stackPush;
        end
    end

    // core mode levels, one cycle behind their registers; power-down clears with its register on wake
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            activeBank         <= 2'h0;
            uartBaudDoubler    <= 1'b0;
            latchStrobeDisable <= 1'b0;
            powerDown          <= 1'b0;
        end else begin
            activeBank         <= {statusWord_reg[`CSR_STS_BANKHI],
                                   statusWord_reg[`CSR_STS_BANKLO]};
            uartBaudDoubler    <= powerControl_reg[`CSR_PWR_BAUD];
            latchStrobeDisable <= powerControl_reg[`CSR_PWR_LATCHOFF];
            // drop at once on wake, so the core loses no cycle
            powerDown          <= powerDownState & ~wakeEvent;
        end
    end

    // data memory map: pointer and on-chip ram decode
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            memoryAddressPointer <= {3{`CSR_RST_PTR}};
            onchipRamSelect      <= 1'b0;
            onchipRamMapEnable   <= 1'b0;
        end else begin
            memoryAddressPointer <= pointerCurrent;
            onchipRamSelect      <= onchipHit(coreConfig_reg[`CSR_CFG_RAMMAP],
                                              pointerCurrent);
            onchipRamMapEnable   <= coreConfig_reg[`CSR_CFG_RAMMAP];
        end
    end
endmodule

/* design/csr_core_defs.vh */
// register addresses, field positions and reset values of the core special registers
`ifndef CSR_CORE_DEFS_VH
`define CSR_CORE_DEFS_VH
`define CSR_ADDR_PWR      8'h87
`define CSR_ADDR_PTRLOW   8'h82
`define CSR_ADDR_PTRHIGH  8'h83
`define CSR_ADDR_PTRPAGE  8'h84
`define CSR_ADDR_STACK    8'h81
`define CSR_ADDR_CFG      8'haf
`define CSR_ADDR_STKUP    8'hb7
`define CSR_ADDR_STATUS   8'hd0
`define CSR_RST_PWR       8'h00
`define CSR_RST_CFG       8'h00
`define CSR_RST_STATUS    8'h00
`define CSR_RST_STACK     8'h07
`define CSR_RST_PTR       8'h00
`define CSR_RST_STKUP     8'h00
`define CSR_PWR_BAUD      7
`define CSR_PWR_SERWAKE   6
`define CSR_PWR_IRQWAKE   5
`define CSR_PWR_LATCHOFF  4
`define CSR_PWR_DOWN      1
`define CSR_PWR_WMASK     8'hfe
`define CSR_CFG_STKEXT    7
`define CSR_CFG_RAMMAP    0
`define CSR_CFG_WMASK     8'h81
`define CSR_STKUP_WMASK   8'h07
`define CSR_STS_CARRY     7
`define CSR_STS_AUX       6
`define CSR_STS_BANKHI    4
`define CSR_STS_BANKLO    3
`define CSR_STS_RANGE     2
`define CSR_STS_PARITY    0
`define CSR_RAM_LIMIT     24'h0007ff
`endif

/* design/csr_power_wake.v */
// power-down state holder with wake detection from serial and external irq 0
module csr_power_wake (
    input  wire clk_sys,
    input  wire rst_n,
    input  wire enterDown,
    input  wire serialWakeEnable,
    input  wire extIrq0WakeEnable,
    input  wire extIrq0EdgeSelect,
    input  wire serialIrq,
    input  wire extIrq0PinN,
    output reg  powerDown_reg,
    output wire wakeEvent
);
    reg  irqSync1_reg;
    reg  irqSync2_reg;
    reg  irqPrev_reg;
    wire irqFall;
    wire irqLow;

    // two-stage synchroniser, pin is asynchronous
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqSync1_reg <= 1'b1;
            irqSync2_reg <= 1'b1;
            irqPrev_reg  <= 1'b1;
        end else begin
            irqSync1_reg <= extIrq0PinN;
            irqSync2_reg <= irqSync1_reg;
            irqPrev_reg  <= irqSync2_reg;
        end
    end

    assign irqLow  = ~irqSync2_reg;
    assign irqFall = irqPrev_reg & ~irqSync2_reg;
    // level or falling edge per select
    assign wakeEvent = powerDown_reg & ((serialWakeEnable & serialIrq) |
                       (extIrq0WakeEnable & (extIrq0EdgeSelect ? irqFall : irqLow)));

    // wake wins over a same-cycle entry request
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            powerDown_reg <= 1'b0;
        end else if (wakeEvent) begin
            powerDown_reg <= 1'b0;
        end else if (enterDown) begin
            powerDown_reg <= 1'b1;
        end
    end
endmodule

/* test/csr_core_regs_assertions.sv */
// concurrent checks on the core special register ports
module csr_core_regs_assertions #(
    parameter ADDR_W = 8,
    parameter DATA_W = 8
) (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] sfrAddr,
    input wire logic              sfrWrite,
    input wire logic              sfrRead,
    input wire logic [DATA_W-1:0] sfrWriteData,
    input wire logic              bitWrite,
    input wire logic              pointerInc,
    input wire logic              stackPush,
    input wire logic              stackPop,
    input wire logic              sfrReadValid,
    input wire logic [23:0]       memoryAddressPointer,
    input wire logic [10:0]       stackAddress,
    input wire logic              stackWriteStrobe,
    input wire logic [1:0]        activeBank,
    input wire logic              uartBaudDoubler,
    input wire logic              latchStrobeDisable,
    input wire logic              powerDown
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // read answer comes exactly one edge after the request
    AST_RD_VALID: assert property (sfrRead |=> sfrReadValid)
        else $error("read answer missing");
    AST_RD_IDLE: assert property (!sfrRead |=> !sfrReadValid)
        else $error("read answer without request");
    // push steps the stack address on the same edge that raises the store strobe
    AST_PUSH_STROBE: assert property (stackPush && !stackPop |=> stackWriteStrobe)
        else $error("push gave no store strobe");
    AST_STK_STEP: assert property (stackWriteStrobe |->
        stackAddress[7:0] == $past(stackAddress[7:0]) + 8'h01)
        else $error("stack step wrong");
    // the pointer output lags the registers, so the step shows two edges on
    AST_PTR_INC: assert property (pointerInc |=> ##1
        memoryAddressPointer == $past(memoryAddressPointer) + 24'h000001)
        else $error("pointer increment wrong");
    // byte writes show at the level outputs two edges later
    AST_BANK: assert property (
        (sfrWrite && sfrAddr == 8'hd0) ##1 !sfrWrite && !bitWrite
        |=> activeBank == $past(sfrWriteData[4:3], 2))
        else $error("bank select wrong");
    AST_BAUD: assert property (
        (sfrWrite && sfrAddr == 8'h87) ##1 !sfrWrite
        |=> uartBaudDoubler == $past(sfrWriteData[7], 2))
        else $error("baud doubler wrong");
    AST_LATCH: assert property (
        (sfrWrite && sfrAddr == 8'h87) ##1 !sfrWrite
        |=> latchStrobeDisable == $past(sfrWriteData[4], 2))
        else $error("latch strobe disable wrong");
    AST_PWR_DOWN: assert property (
        sfrWrite && sfrAddr == 8'h87 && sfrWriteData[1] && !powerDown
        |=> ##1 powerDown)
        else $error("power-down not entered");
endmodule

/* test/csr_wake_source.sv */
// stand-in for the serial and external irq 0 wake sources
module csr_wake_source (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic fireSerial,
    input  wire logic fireIrq,
    output logic      serialIrq,
    output logic      extIrq0PinN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] holdCnt_reg;

    // request lasts five cycles, pin then returns to its pull-up level
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            holdCnt_reg <= 3'h0;
            serialIrq   <= 1'b0;
            extIrq0PinN <= 1'b1;
        end else if (fireSerial || fireIrq) begin
            holdCnt_reg <= 3'h4;
            serialIrq   <= fireSerial;
            extIrq0PinN <= !fireIrq;
        end else if (holdCnt_reg != 3'h0) begin
            holdCnt_reg <= holdCnt_reg - 3'h1;
        end else begin
            serialIrq   <= 1'b0;
            extIrq0PinN <= 1'b1;
        end
    end
endmodule

/* test/csr_core_regs_test.sv */
// self-checking bench for the core special registers
module csr_core_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 0, rst_n = 0, sfrWrite = 0, sfrRead = 0, bitWrite = 0, bitValue = 0;
    logic        pointerInc = 0, stackPush = 0, stackPop = 0, flagsUpdate = 0;
    logic        extIrq0EdgeSelect = 0, fireSerial = 0, fireIrq = 0, serialIrq, extIrq0PinN;
    logic [7:0]  sfrAddr = 0, sfrWriteData = 0, sfrReadData;
    logic [2:0]  bitIndex = 0;
    logic [3:0]  flagsIn = 0;
    logic        sfrReadValid, stackWriteStrobe, uartBaudDoubler, latchStrobeDisable;
    logic        powerDown, onchipRamSelect, onchipRamMapEnable, strobeSeen;
    logic [23:0] memoryAddressPointer;
    logic [10:0] stackAddress;
    logic [1:0]  activeBank;
    int          numErrors = 0, nTests = 0;
    // address, written byte, expected read-back
    logic [23:0] rows [12] = '{24'h87fdfc, 24'h870000, 24'hafff81, 24'hb7ff07, 24'haf0000,
        24'hb70500, 24'hd0a5a5, 24'h841212, 24'h833434, 24'h825656, 24'h815a5a, 24'h90ff00};

    csr_core_regs dut (.clk_sys, .rst_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData,
        .bitWrite, .bitIndex, .bitValue, .pointerInc, .stackPush, .stackPop, .flagsUpdate,
        .flagsIn, .serialIrq, .extIrq0PinN, .extIrq0EdgeSelect, .sfrReadData, .sfrReadValid,
        .memoryAddressPointer, .stackAddress, .stackWriteStrobe, .activeBank, .uartBaudDoubler,
        .latchStrobeDisable, .powerDown, .onchipRamSelect, .onchipRamMapEnable);
    csr_wake_source partner (.clk_sys, .rst_n, .fireSerial, .fireIrq, .serialIrq, .extIrq0PinN);

    // 10 MHz core clock
    always #50 clk_sys = ~clk_sys;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // level outputs lag the register by one edge
    task automatic settle;
        cyc(2);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrWriteData <= d;
        sfrWrite <= 1'b1;
        @(posedge clk_sys);
        sfrWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge clk_sys);
        sfrRead <= 1'b0;
        #1;
        chk({sfrReadValid, sfrReadData}, {1'b1, exp});
    endtask

    // one-cycle strobe; store strobe caught while it stands, level outputs one edge later
    task automatic pulse(input int k);
        @(posedge clk_sys);
        case (k)
            0: pointerInc <= 1'b1;
            1: stackPush <= 1'b1;
            2: stackPop <= 1'b1;
            3: flagsUpdate <= 1'b1;
            default: bitWrite <= 1'b1;
        endcase
        @(posedge clk_sys);
        {pointerInc, stackPush, stackPop, flagsUpdate, bitWrite} <= 5'h00;
        #1;
        strobeSeen = stackWriteStrobe;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_wake;
        for (int i = 0; i < 64 && powerDown !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        nTests++;
        if (powerDown !== 1'b0) begin
            numErrors++;
            $display("[FAIL] %0t no wake from power-down", $time);
            end_of_test();
        end
    endtask

    task automatic end_of_test;
        if (numErrors == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        int i;
        cyc(16);
        rst_n <= 1'b1;
        settle();
        chk(stackAddress, 24'h000007);
        rd(8'h87, 8'h00);
        rd(8'haf, 8'h00);
        rd(8'hd0, 8'h00);
        pulse(1);
        chk({strobeSeen, stackAddress}, {1'b1, 11'h008});
        pulse(2);
        chk(stackAddress, 24'h000007);
        for (i = 0; i < 12; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        // hidden upper bits kept their value through the ignored write
        wr(8'haf, 8'h80);
        rd(8'hb7, 8'h07);
        wr(8'hb7, 8'h00);
        wr(8'h81, 8'hff);
        pulse(1);
        chk(stackAddress, 24'h000100);
        rd(8'hb7, 8'h01);
        wr(8'haf, 8'h00);
        wr(8'h81, 8'hff);
        pulse(1);
        chk(stackAddress[7:0], 24'h000000);
        wr(8'h84, 8'h00);
        wr(8'h83, 8'hff);
        wr(8'h82, 8'hff);
        pulse(0);
        chk(memoryAddressPointer, 24'h010000);
        rd(8'h84, 8'h01);
        wr(8'haf, 8'h01);
        wr(8'h84, 8'h00);
        wr(8'h83, 8'h07);
        wr(8'h82, 8'hff);
        settle();
        chk({onchipRamMapEnable, onchipRamSelect}, 24'h000003);
        pulse(0);
        settle();
        chk({memoryAddressPointer, onchipRamSelect}, {24'h000800, 1'b0});
        wr(8'h83, 8'h00);
        wr(8'haf, 8'h00);
        settle();
        chk({onchipRamMapEnable, onchipRamSelect}, 24'h000000);
        for (i = 0; i < 4; i++) begin
            wr(8'hd0, 8'(i << 3));
            settle();
            chk(activeBank, 24'(i));
        end
        @(posedge clk_sys);
        bitIndex <= 3'h4;
        pulse(4);
        chk(activeBank, 24'h000001);
        @(posedge clk_sys);
        flagsIn <= 4'hf;
        pulse(3);
        rd(8'hd0, 8'hcd);
        // serial wake, then irq 0 by level and by falling edge
        for (i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            extIrq0EdgeSelect <= (i == 2);
            wr(8'h87, (i == 0) ? 8'h42 : 8'h22);
            settle();
            chk(powerDown, 24'h000001);
            @(posedge clk_sys);
            fireSerial <= (i == 0);
            fireIrq <= (i != 0);
            cyc(1);
            {fireSerial, fireIrq} <= 2'b00;
            wait_wake();
        end
        end_of_test();
    end
endmodule

bind csr_core_regs csr_core_regs_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) regsChk (
    .clk_sys, .rst_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData, .bitWrite, .pointerInc,
    .stackPush, .stackPop, .sfrReadValid, .memoryAddressPointer, .stackAddress,
    .stackWriteStrobe, .activeBank, .uartBaudDoubler, .latchStrobeDisable, .powerDown);
